//--- msg_gen.sv
// Summary of operation
// - static polarity: mark negative by default, positive when selected
// - stop bit 1.0 unit, 1.5 when select input grounded or strap set
// - 38.4 kHz reference divided by 10-stage counter, even ratios only
// - divide factor is reference over baud times half, sum of weights
// - overall ratio stays even; software rounds non-integer factors
// - no weights selected gives 37.5 baud; all weights set gives the lowest rate
// - serial rates up to 19200 baud supported
// - store holds 80 entries, read in order, entry n sent nth
// - five data bits plus end flag; set bit is mark, clear is space
// - after the flagged entry the scanner returns to entry one
// - mark indicator output active whenever line is at mark
// - reversals mode ignores store, toggles line each bit period
// - mark mode holds steady mark, sends no characters
// - step mode sends one character per step pulse, then idles mark
// - run mode sends the message continuously, wrapping to entry one
// - burst mode sends from the current entry through the flagged entry once triggered
// - frame opens with space start bit and ends with mark stop bit
`timescale 1ns/1ps
`default_nettype none

module msg_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = ce & in_valid & in_ready;
	wire pop = ce & out_valid & out_ready;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module msg_gen #(
	parameter int DEPTH = msg_gen_pkg::MSG_DEPTH,
	parameter int FIFO_DEPTH = msg_gen_pkg::FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic step_in,
	input wire logic burst_in,
	input wire logic long_stop_b,
	output logic ser_out,
	output logic mark_ind
);
	localparam int EW = $bits(msg_gen_pkg::msg_entry_t);
	// registers
	logic [4:0] ctrl;
	logic [msg_gen_pkg::DIV_W-1:0] divide;
	msg_gen_pkg::msg_word_t store [DEPTH];

	// timebase
	logic [msg_gen_pkg::NCO_W-1:0] nco_acc;
	logic ref_tick;
	logic [msg_gen_pkg::DIV_W:0] div_cnt;

	// transmitter
	msg_gen_pkg::tx_state_t state;
	msg_gen_pkg::tx_state_t next_state;
	logic [msg_gen_pkg::IDX_W-1:0] scan_idx;
	logic [msg_gen_pkg::DATA_BITS-1:0] shreg;
	logic [2:0] bit_no;
	logic [1:0] half_cnt;
	logic last_eom;
	logic rev_mark;
	logic line_mark;
	logic step_prev;
	logic burst_prev;
	logic step_pend;
	logic burst_active;
	// bus decode
	wire setup = psel & ~penable;
	wire access = psel & penable & ~pready;
	wire done = psel & penable & pready;
	wire hit_ctrl = (paddr == msg_gen_pkg::OFS_CTRL);
	wire hit_div = (paddr == msg_gen_pkg::OFS_DIVIDE);
	wire hit_msg = (paddr == msg_gen_pkg::OFS_MSG_WRITE);
	wire hit_stat = (paddr == msg_gen_pkg::OFS_STATUS);
	wire mapped = hit_ctrl | hit_div | hit_msg | hit_stat;
	wire fifo_in_ready;
	// a full message queue stretches the access phase
	wire acc_ok = ~(pwrite & hit_msg) | fifo_in_ready;
	wire wr_done = done & pwrite & ~pslverr;
	// message queue between bus and store
	wire fifo_out_valid;
	wire fifo_out_ready;
	wire [EW-1:0] fifo_out;
	wire msg_gen_pkg::msg_entry_t entry_in = msg_gen_pkg::msg_entry_t'({
		pwdata[msg_gen_pkg::MW_IDX_LSB +: msg_gen_pkg::IDX_W],
		pwdata[msg_gen_pkg::MW_EOM_BIT:0]});
	wire msg_gen_pkg::msg_entry_t entry_out = fifo_out;
	// store updates wait for the line to go idle, so the queue really fills
	assign fifo_out_ready = (state == msg_gen_pkg::TX_IDLE);
	wire store_wr = ce & fifo_out_valid & fifo_out_ready &
		(entry_out.idx < DEPTH[msg_gen_pkg::IDX_W-1:0]);
	msg_fifo #(
		.WIDTH(EW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.ce(ce),
		.in_valid(wr_done & hit_msg),
		.in_ready(fifo_in_ready),
		.in_data(entry_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);
	// control decode
	wire [2:0] mode_raw = ctrl[msg_gen_pkg::CTRL_MODE_LSB +: 3];
	wire pol_pos = ctrl[msg_gen_pkg::CTRL_POL_BIT];
	wire long_stop = ~long_stop_b | ctrl[msg_gen_pkg::CTRL_STRAP_BIT];
	wire is_rev = (mode_raw == msg_gen_pkg::MODE_REVERSALS);
	wire is_step = (mode_raw == msg_gen_pkg::MODE_STEP);
	wire is_run = (mode_raw == msg_gen_pkg::MODE_RUN);
	wire is_burst = (mode_raw == msg_gen_pkg::MODE_BURST);
	// reference tick: 38.4 kHz from the core clock by phase accumulation
	wire [msg_gen_pkg::NCO_W-1:0] nco_sum =
		nco_acc + msg_gen_pkg::NCO_W'(msg_gen_pkg::NCO_STEP);
	wire nco_wrap = (nco_sum >= msg_gen_pkg::NCO_W'(msg_gen_pkg::NCO_MOD));
	// half-bit period: factor in reference cycles, twice per bit keeps
	// the overall ratio even; an empty setting falls to 512
	wire [msg_gen_pkg::DIV_W:0] half_len = (divide == '0) ?
		msg_gen_pkg::DIV_EMPTY_HALF : {1'b0, divide};
	// the divider is held clear between frames, like the enable clamp
	wire div_run = (state != msg_gen_pkg::TX_IDLE) | is_rev;
	wire half_tick = div_run & ref_tick &
		(div_cnt == half_len - 1'b1);
	// triggers, taken on the rising level of the outside pulse
	wire step_rise = step_in & ~step_prev;
	wire burst_rise = burst_in & ~burst_prev;
	// whether another frame follows the current one
	wire want_frame = (is_step & step_pend) | is_run |
		(is_burst & (burst_active | burst_rise));
	// frame sequencing
	wire msg_gen_pkg::msg_word_t cur = store[scan_idx];
	wire [1:0] stop_halves = long_stop ? msg_gen_pkg::HALVES_STOP_LONG :
		msg_gen_pkg::HALVES_BIT;
	wire bit_end = half_tick & (half_cnt == msg_gen_pkg::HALVES_BIT - 1'b1);
	wire stop_end = half_tick & (half_cnt == stop_halves - 1'b1);
	wire last_bit = (bit_no == 3'(msg_gen_pkg::DATA_BITS - 1));
	wire start_go = (state == msg_gen_pkg::TX_IDLE) & want_frame &
		~is_rev & ~fifo_out_valid;
	wire frame_end = (state == msg_gen_pkg::TX_STOP) & stop_end;
	wire wrap_idx = last_eom |
		(scan_idx == msg_gen_pkg::IDX_W'(DEPTH - 1));
	wire [msg_gen_pkg::IDX_W-1:0] next_idx = wrap_idx ? '0 :
		scan_idx + 1'b1;
	always_comb begin
		next_state = state;
		unique case (state)
			msg_gen_pkg::TX_IDLE: begin
				if (start_go) begin
					next_state = msg_gen_pkg::TX_START;
				end
			end
			msg_gen_pkg::TX_START: begin
				if (bit_end) begin
					next_state = msg_gen_pkg::TX_DATA;
				end
			end
			msg_gen_pkg::TX_DATA: begin
				if (bit_end & last_bit) begin
					next_state = msg_gen_pkg::TX_STOP;
				end
			end
			msg_gen_pkg::TX_STOP: begin
				if (stop_end) begin
					next_state = msg_gen_pkg::TX_IDLE;
				end
			end
		endcase
	end
	// shift contents for the cycle after this one
	wire [msg_gen_pkg::DATA_BITS-1:0] next_shreg =
		(state == msg_gen_pkg::TX_START) ? shreg :
		(bit_end ? (shreg >> 1) : shreg);
	// line level in mark terms, from the shifted value so bits keep time
	logic next_mark;
	always_comb begin
		next_mark = 1'b1;
		unique case (next_state)
			msg_gen_pkg::TX_IDLE: next_mark = is_rev ? rev_mark : 1'b1;
			msg_gen_pkg::TX_START: next_mark = 1'b0;
			msg_gen_pkg::TX_DATA: next_mark = next_shreg[0];
			msg_gen_pkg::TX_STOP: next_mark = 1'b1;
		endcase
	end
	// read mux
	wire [31:0] status_word = {16'h0000, 1'b0, scan_idx,
		fifo_in_ready, fifo_out_valid, burst_active, step_pend,
		line_mark, 1'b0, state};
	wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl} :
		hit_div ? {22'h0, divide} :
		hit_stat ? status_word : 32'h0;
	// bus slave
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (ce) begin
			pready <= access & acc_ok;
			if (setup) begin
				pslverr <= ~mapped;
			end
			if (access & ~pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= msg_gen_pkg::CTRL_RESET;
			divide <= msg_gen_pkg::DIV_RESET;
		end else if (ce & wr_done) begin
			if (hit_ctrl) begin
				ctrl <= pwdata[4:0];
			end
			if (hit_div) begin
				divide <= pwdata[msg_gen_pkg::DIV_W-1:0];
			end
		end
	end
	// message store; one end flag per message is software's job
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < DEPTH; i++) begin
				store[i] <= '0;
			end
		end else if (store_wr) begin
			store[entry_out.idx] <= {entry_out.eom, entry_out.bits};
		end
	end

	// timebase
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			nco_acc <= '0;
			ref_tick <= 1'b0;
		end else if (ce) begin
			nco_acc <= nco_wrap ?
				nco_sum - msg_gen_pkg::NCO_W'(msg_gen_pkg::NCO_MOD) : nco_sum;
			ref_tick <= nco_wrap;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_cnt <= '0;
		end else if (ce) begin
			if (!div_run | half_tick) begin
				div_cnt <= '0;
			end else if (ref_tick) begin
				div_cnt <= div_cnt + 1'b1;
			end
		end
	end
	// triggers; a new pulse outranks the clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			step_prev <= 1'b0;
			burst_prev <= 1'b0;
			step_pend <= 1'b0;
			burst_active <= 1'b0;
		end else if (ce) begin
			step_prev <= step_in;
			burst_prev <= burst_in;
			if (step_rise & is_step) begin
				step_pend <= 1'b1;
			end else if (start_go | ~is_step) begin
				step_pend <= 1'b0;
			end
			if (burst_rise & is_burst) begin
				burst_active <= 1'b1;
			end else if ((frame_end & last_eom) | ~is_burst) begin
				burst_active <= 1'b0;
			end
		end
	end
	// transmitter state
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= msg_gen_pkg::TX_IDLE;
			half_cnt <= '0;
			bit_no <= '0;
		end else if (ce) begin
			state <= next_state;
			if (state != next_state) begin
				half_cnt <= '0;
			end else if (half_tick) begin
				half_cnt <= (half_cnt == msg_gen_pkg::HALVES_BIT - 1'b1 &&
					state != msg_gen_pkg::TX_STOP) ? '0 : half_cnt + 1'b1;
			end
			if (state == msg_gen_pkg::TX_START) begin
				bit_no <= '0;
			end else if (bit_end) begin
				bit_no <= bit_no + 1'b1;
			end
		end
	end
	// scanner and shifter
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scan_idx <= '0;
			shreg <= '0;
			last_eom <= 1'b0;
		end else if (ce) begin
			if (start_go) begin
				shreg <= cur.bits;
				last_eom <= cur.eom;
			end else begin
				shreg <= next_shreg;
			end
			if (frame_end) begin
				scan_idx <= next_idx;
			end
		end
	end
	// reversals toggle every bit period
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rev_mark <= 1'b1;
		end else if (ce) begin
			if (!is_rev) begin
				rev_mark <= 1'b1;
			end else if (bit_end) begin
				rev_mark <= ~rev_mark;
			end
		end
	end
	// line outputs
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			line_mark <= 1'b1;
			mark_ind <= 1'b1;
			ser_out <= 1'b0;
		end else if (ce) begin
			line_mark <= next_mark;
			mark_ind <= next_mark;
			// high is the positive level
			ser_out <= pol_pos ? next_mark : ~next_mark;
		end
	end
endmodule

`default_nettype wire

//--- msg_gen_pkg.sv
package msg_gen_pkg;

	// clock and reference timebase
	localparam int CLK_HZ = 20000000;
	localparam int REF_HZ = 38400;
	// common factor of both rates keeps the phase accumulator narrow
	localparam int NCO_GCD = 800;
	localparam int NCO_MOD = CLK_HZ / NCO_GCD;
	localparam int NCO_STEP = REF_HZ / NCO_GCD;
	localparam int NCO_W = 15;

	// divider: 10 stages, empty setting gives 1024 reference cycles per bit
	localparam int DIV_W = 10;
	localparam logic [DIV_W:0] DIV_EMPTY_HALF = 11'h200;
	localparam logic [DIV_W-1:0] DIV_RESET = 10'h000;

	// frame timing in half-bit units
	localparam logic [1:0] HALVES_BIT = 2'h2;
	localparam logic [1:0] HALVES_STOP_LONG = 2'h3;
	localparam int DATA_BITS = 5;

	// message store
	localparam int MSG_DEPTH = 80;
	localparam int IDX_W = 7;
	localparam int FIFO_DEPTH = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DIVIDE = 8'h04;
	localparam logic [7:0] OFS_MSG_WRITE = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;

	// control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_POL_BIT = 3;
	localparam int CTRL_STRAP_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h01;

	// message write fields
	localparam int MW_EOM_BIT = 5;
	localparam int MW_IDX_LSB = 8;

	typedef enum logic [2:0] {
		MODE_REVERSALS,
		MODE_MARK,
		MODE_STEP,
		MODE_RUN,
		MODE_BURST
	} op_mode_t;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_STOP
	} tx_state_t;

	typedef struct packed {
		logic [IDX_W-1:0] idx;
		logic eom;
		logic [DATA_BITS-1:0] bits;
	} msg_entry_t;

	typedef struct packed {
		logic eom;
		logic [DATA_BITS-1:0] bits;
	} msg_word_t;

endpackage

//--- msg_gen_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module msg_gen_assertions #(
	parameter int DEPTH = 80,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic step_in,
	input wire logic burst_in,
	input wire logic long_stop_b,
	input wire logic ser_out,
	input wire logic mark_ind
);
	localparam int QUIET = 8000;
	logic [4:0] ctrl;
	logic pol_q;
	logic [13:0] quiet;
	wire ctrl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
	wire mark_mode = ctrl[2:0] == 3'h1 || ctrl[2:0] > 3'h4;
	// pol_q lags one cycle: the line flop follows the register a cycle late
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= msg_gen_pkg::CTRL_RESET;
			pol_q <= 1'b0;
			quiet <= 14'h0;
		end else begin
			pol_q <= ctrl[3];
			if (ctrl_wr)
				ctrl <= pwdata[4:0];
			quiet <= ctrl_wr ? 14'h0 : (quiet < 14'(QUIET) ? quiet + 14'h1 : quiet);
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence s_setup;
		psel && !penable && paddr != 8'h08;
	endsequence
	sequence s_answer;
		penable && !pready ##1 pready;
	endsequence
	AST_APB_ANSWER: assert property (s_setup |=> s_answer)
		else $error("apb answer not on second access cycle");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_READY_CAUSE: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	AST_DECODE_ERR: assert property (pready |-> pslverr == !(paddr == 8'h00 ||
		paddr == 8'h04 || paddr == 8'h08 || paddr == 8'h0c))
		else $error("pslverr does not follow address map");
	AST_ERR_DATA: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0)
		else $error("refused read returned data");
	AST_CTRL_READ: assert property (pready && !pwrite && paddr == 8'h00
		|-> prdata == {27'h0, ctrl})
		else $error("control readback differs from last write");
	AST_POL_MARK: assert property (pol_q == ctrl[3] |->
		mark_ind == (ser_out == ctrl[3]))
		else $error("mark indicator disagrees with line and polarity");
	AST_MARK_MODE: assert property (mark_mode && quiet >= 14'(QUIET) |-> mark_ind)
		else $error("line left mark in steady mark mode");
	AST_START_SPACE: assert property ($fell(mark_ind) |-> !mark_ind [*8])
		else $error("space shorter than a bit");
	AST_BIT_MARK: assert property ($rose(mark_ind) |-> mark_ind [*8])
		else $error("mark shorter than a bit");
endmodule
bind msg_gen msg_gen_assertions #(.DEPTH(DEPTH), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
	.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .step_in(step_in),
	.burst_in(burst_in), .long_stop_b(long_stop_b), .ser_out(ser_out),
	.mark_ind(mark_ind));
`default_nettype wire

//--- msg_term_model.sv
`timescale 1ns/1ps
`default_nettype none
module msg_term_model #(
	parameter int BIT_CYC = 1042
) (
	input wire logic core_clk,
	input wire logic ser_out,
	input wire logic pol,
	output logic [4:0] last_char,
	output int count,
	output int tail,
	output int frame_err
);
	wire mark = ser_out == pol;
	int run_len = 0;
	int cur;
	logic [4:0] c;
	// mark cycles ahead of each start give the stop length
	always @(posedge core_clk) run_len <= mark ? run_len + 1 : 0;
	initial begin
		count = 0;
		tail = 0;
		frame_err = 0;
		last_char = 5'h00;
		forever begin
			@(posedge core_clk);
			if (!mark) begin
				cur = run_len;
				repeat (BIT_CYC / 2) @(posedge core_clk);
				// short space is a polarity switch glitch, not a start
				if (!mark) begin
					for (int i = 0; i < 5; i++) begin
						repeat (BIT_CYC) @(posedge core_clk);
						c[i] = mark;
					end
					repeat (BIT_CYC) @(posedge core_clk);
					if (!mark)
						frame_err++;
					last_char = c;
					tail = cur;
					count++;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- msg_gen_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module msg_gen_tb_top;
	typedef struct {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] rd;
		logic err;
	} row_t;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic step_in = 1'b0;
	logic burst_in = 1'b0;
	logic long_stop_b = 1'b1;
	logic pol = 1'b0;
	logic [31:0] prdata, rd, st;
	logic pready, pslverr, ser_out, mark_ind, err;
	logic [4:0] last_char;
	logic [4:0] msg [3] = '{5'h0b, 5'h06, 5'h15};
	int count, tail, frame_err, span, c, idx;
	int bad_count = 0;
	int check_count = 0;
	time t0;
	row_t rows [10] = '{
		'{1'b0, 8'h00, 32'h0, 32'h01, 1'b0},
		'{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h0c, 32'h0, 32'h88, 1'b0},
		'{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'h0, 1'b1},
		'{1'b1, 8'h04, 32'h3ff, 32'h0, 1'b0},
		'{1'b0, 8'h04, 32'h0, 32'h3ff, 1'b0},
		'{1'b1, 8'h00, 32'h1f, 32'h0, 1'b0},
		'{1'b0, 8'h00, 32'h0, 32'h1f, 1'b0},
		'{1'b1, 8'h04, 32'h1, 32'h0, 1'b0}
	};

	always #25 core_clk = ~core_clk;

	msg_gen dut_u (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .step_in(step_in),
		.burst_in(burst_in), .long_stop_b(long_stop_b), .ser_out(ser_out),
		.mark_ind(mark_ind));
	msg_term_model #(.BIT_CYC(1042)) term_u (.core_clk(core_clk),
		.ser_out(ser_out), .pol(pol), .last_char(last_char), .count(count),
		.tail(tail), .frame_err(frame_err));

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int w;
		w = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// a full message queue stalls until the current frame ends
		do begin
			@(posedge core_clk);
			w++;
		end while (pready !== 1'b1 && w < 20000);
		r = prdata;
		e = pslverr;
		if (w >= 20000)
			bad_count++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic wait_count(input int k);
		int w;
		w = 0;
		while (count < k && w < 10000) begin
			@(posedge core_clk);
			w++;
		end
		if (w >= 10000)
			bad_count++;
	endtask

	task automatic wait_edge(output int w);
		logic m;
		m = mark_ind;
		w = 0;
		do begin
			@(posedge core_clk);
			w++;
		end while (mark_ind === m && w < 8000);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d, rd, err);
			check("pslverr", {31'h0, err}, {31'h0, rows[i].err});
			if (!rows[i].wr)
				check("prdata", rd, rows[i].rd);
		end
		apb(1'b1, 8'h00, 32'h01, rd, err);
		for (int k = 0; k < 3; k++)
			apb(1'b1, 8'h08, {17'h0, 7'(k), 2'h0, k == 2, msg[k]}, rd, err);
		apb(1'b1, 8'h00, 32'h03, rd, err);
		repeat (100) @(posedge core_clk);
		// dropped indexes fill the queue without touching the message
		for (int k = 0; k < 9; k++) begin
			if (k == 8) begin
				apb(1'b0, 8'h0c, 32'h0, st, err);
				check("fifo_full", {31'h0, st[7]}, 32'h0);
				t0 = $time;
			end
			apb(1'b1, 8'h08, {17'h0, 7'(80 + k), 8'h0}, rd, err);
		end
		check("stall", {31'h0, $time - t0 > 5000}, 32'h1);
		for (int k = 1; k < 6; k++) begin
			wait_count(k);
			check("char", {27'h0, last_char}, {27'h0, msg[(k - 1) % 3]});
			if (k == 3)
				check("stop", {31'h0, tail > 1036 && tail < 1048}, 32'h1);
			if (k == 3)
				long_stop_b <= 1'b0;
		end
		check("stop_long", {31'h0, tail > 1556 && tail < 1568}, 32'h1);
		long_stop_b <= 1'b1;
		apb(1'b1, 8'h00, 32'h01, rd, err);
		repeat (9000) @(posedge core_clk);
		pol <= 1'b1;
		apb(1'b1, 8'h00, 32'h0a, rd, err);
		apb(1'b0, 8'h0c, 32'h0, st, err);
		idx = int'(st[14:8]);
		c = count;
		step_in <= 1'b1;
		repeat (20000) @(posedge core_clk);
		step_in <= 1'b0;
		repeat (200) @(posedge core_clk);
		check("step_count", 32'(count - c), 32'h1);
		check("step_char", {27'h0, last_char}, {27'h0, msg[idx % 3]});
		apb(1'b1, 8'h00, 32'h0c, rd, err);
		apb(1'b0, 8'h0c, 32'h0, st, err);
		idx = int'(st[14:8]);
		c = count;
		burst_in <= 1'b1;
		repeat (20000) @(posedge core_clk);
		burst_in <= 1'b0;
		repeat (3000) @(posedge core_clk);
		check("burst_count", 32'(count - c), 32'(3 - idx));
		apb(1'b0, 8'h0c, 32'h0, st, err);
		check("fifo_empty", {31'h0, st[6]}, 32'h0);
		check("frame_err", 32'(frame_err), 32'h0);
		apb(1'b1, 8'h04, 32'h3, rd, err);
		apb(1'b1, 8'h00, 32'h08, rd, err);
		wait_edge(span);
		wait_edge(span);
		check("reversal", {31'h0, span > 3121 && span < 3129}, 32'h1);
		// reset in mid-reversal drops line and bus back to idle at once
		pol <= 1'b0;
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		check("rst_ser_out", {31'h0, ser_out}, 32'h0);
		check("rst_mark_ind", {31'h0, mark_ind}, 32'h1);
		check("rst_pready", {31'h0, pready}, 32'h0);
		check("rst_prdata", prdata, 32'h0);
		rst_b <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, 8'h00, 32'h0, rd, err);
		check("rst_ctrl", rd, 32'h01);
		apb(1'b0, 8'h0c, 32'h0, st, err);
		check("rst_status", st, 32'h88);
		results();
	end

	initial begin
		repeat (110000) @(posedge core_clk);
		bad_count++;
		results();
	end
endmodule
`default_nettype wire
